// ===== core/rms_pkg.sv
// rms_pkg: constants and types of the radio mode sequencer.
// assumes a 20 MHz reference clock; all times are derived from it.
package rms_pkg;

	// register addresses on the 7-bit serial address space
	localparam logic [6:0] ADR_STAT = 7'h02;
	localparam logic [6:0] ADR_IST1 = 7'h03;
	localparam logic [6:0] ADR_IST2 = 7'h04;
	localparam logic [6:0] ADR_IEN1 = 7'h05;
	localparam logic [6:0] ADR_IEN2 = 7'h06;
	localparam logic [6:0] ADR_MODE = 7'h07;
	localparam logic [6:0] ADR_SEQC = 7'h0c;
	localparam logic [6:0] ADR_XOSC = 7'h62;

	// values after reset, and the mask of used status 1 bits
	localparam logic [7:0] IEN1_RST = 8'h00;
	localparam logic [7:0] IEN2_RST = 8'h01;
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] SEQC_RST = 8'h01;
	localparam logic [7:0] XOSC_RST = 8'h00;
	localparam logic [7:0] IST1_USED = 8'h9b;

	// register field and event bit positions
	localparam int MB_XTON  = 0;
	localparam int MB_PLLON = 1;
	localparam int MB_RXON  = 2;
	localparam int MB_LBD   = 5;
	localparam int MB_WT    = 6;
	localparam int MB_SWRES = 7;
	localparam int SB_CAL   = 0;
	localparam int XB_BUFOVR = 1;
	localparam int EV_POR   = 8;
	localparam int EV_RDY   = 9;

	// chip power state codes
	localparam logic [1:0] CPS_IDLE = 2'h0;
	localparam logic [1:0] CPS_RX   = 2'h1;
	localparam logic [1:0] CPS_TUNE = 2'h2;

	// times to receive and their split over the sequence steps
	localparam int CLK_MHZ      = 20;
	localparam int T_RX_SHDN_US = 16800;
	localparam int T_RX_IDLE_US = 800;
	localparam int T_RX_FAST_US = 200;
	localparam int POR_US    = T_RX_SHDN_US - T_RX_IDLE_US;
	localparam int XTAL_US   = T_RX_IDLE_US - T_RX_FAST_US;
	localparam int CAL_US    = T_RX_FAST_US / 2;
	localparam int SETTLE_US = T_RX_FAST_US - CAL_US;
	localparam int POR_CYC    = POR_US * CLK_MHZ;
	localparam int XTAL_CYC   = XTAL_US * CLK_MHZ;
	localparam int CAL_CYC    = CAL_US * CLK_MHZ;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int TW = 20;

	typedef enum logic [3:0] {
		ST_SHDN = 4'h0,
		ST_POR  = 4'h1,
		ST_IDLE = 4'h2,
		ST_XTAL = 4'h3,
		ST_SYN  = 4'h4,
		ST_CAL  = 4'h5,
		ST_SET  = 4'h6,
		ST_RXFE = 4'h7,
		ST_RX   = 4'h8
	} rms_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rms_bus_t;

	typedef struct packed {
		logic lp_reg;
		logic main_reg;
		logic xtal;
		logic synth;
		logic rx_fe;
		logic modem_rx;
		logic wut;
		logic lbd;
	} rms_pwr_t;

endpackage

// ===== core/rms_tmr.sv
// rms_tmr: down counter that pulses done a fixed time after start.
// assumes start is a one-cycle pulse; a new start reloads the count.
`timescale 1ns/10ps
module rms_tmr #(
	parameter int W = 20
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	output logic              done
);
	import rms_pkg::*;

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         done_r;
	logic         done_nxt;

	// count down; done fires on the step from one to zero
	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		if (start) begin
			cnt_nxt = load;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - W'(1);
			done_nxt = (cnt_r == W'(1));
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
endmodule

// ===== core/rms_spi.sv
// rms_spi: 16-bit serial register port with burst address increment.
// assumes pins synchronous to ref_clk; sclk high and low >= 3 cycles.
`timescale 1ns/10ps
module rms_spi (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       en,
	input  wire logic       sclk,
	input  wire logic       sdi,
	input  wire logic       sel_n,
	input  wire logic [7:0] rdata,
	output rms_pkg::rms_bus_t bus,
	output logic            sdo,
	output logic            sdo_oe_n
);
	import rms_pkg::*;

	logic       sclk_q_r;
	logic       hdr_r, hdr_nxt;
	logic       rw_r, rw_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [6:0] adr_r, adr_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] out_r, out_nxt;
	logic       sdo_r, sdo_nxt;
	logic       oe_n_r, oe_n_nxt;
	logic       pf_r, pf_nxt;
	logic       cl_r, cl_nxt;
	rms_bus_t   bus_r, bus_nxt;

	// shift on rising sclk, drive on falling; a burst byte is fetched at
	// the fall that starts it, but its flags clear only at the next rise,
	// so a host that stops after one byte loses no flags of the next one;
	// limitation: an event between that fall and rise is cleared unseen
	always_comb begin
		hdr_nxt = hdr_r;
		rw_nxt = rw_r;
		cnt_nxt = cnt_r;
		adr_nxt = adr_r;
		sh_nxt = sh_r;
		out_nxt = out_r;
		sdo_nxt = sdo_r;
		oe_n_nxt = oe_n_r;
		pf_nxt = pf_r;
		cl_nxt = cl_r;
		bus_nxt = bus_r;
		bus_nxt.wr = 1'b0;
		bus_nxt.rd = 1'b0;
		if (!en || sel_n) begin
			hdr_nxt = 1'b0;
			cnt_nxt = 3'h0;
			sdo_nxt = 1'b1;   // pulled high when deselected
			oe_n_nxt = 1'b1;
			pf_nxt = 1'b0;
			cl_nxt = 1'b0;
		end else begin
			if (sclk && !sclk_q_r) begin
				sh_nxt = {sh_r[6:0], sdi};
				cnt_nxt = cnt_r + 3'h1;
				if (cl_r) begin
					bus_nxt.rd = 1'b1;
					cl_nxt = 1'b0;
				end
				if (cnt_r == 3'h7) begin
					if (!hdr_r) begin
						hdr_nxt = 1'b1;
						rw_nxt = sh_nxt[7];
						adr_nxt = sh_nxt[6:0];
						bus_nxt.rd = ~sh_nxt[7];
						bus_nxt.addr = sh_nxt[6:0];
					end else begin
						adr_nxt = adr_r + 7'h01;
						bus_nxt.addr = rw_r ? adr_r : adr_nxt;
						bus_nxt.wr = rw_r;
						pf_nxt = ~rw_r;
						bus_nxt.wdata = sh_nxt;
					end
				end
			end
			// only the first byte loads here; burst bytes load at a fall
			if (bus_r.rd && oe_n_r) begin
				out_nxt = rdata;
			end
			if (!sclk && sclk_q_r && hdr_r && !rw_r) begin
				sdo_nxt = out_r[7];
				out_nxt = {out_r[6:0], 1'b0};
				oe_n_nxt = 1'b0;
				if (pf_r) begin
					sdo_nxt = rdata[7];
					out_nxt = {rdata[6:0], 1'b0};
					pf_nxt = 1'b0;
					cl_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_q_r <= 1'b0;
			hdr_r <= 1'b0;
			rw_r <= 1'b0;
			cnt_r <= 3'h0;
			adr_r <= 7'h00;
			sh_r <= 8'h00;
			out_r <= 8'h00;
			sdo_r <= 1'b1;
			oe_n_r <= 1'b1;
			pf_r <= 1'b0;
			cl_r <= 1'b0;
			bus_r <= '0;
		end else begin
			sclk_q_r <= sclk;
			hdr_r <= hdr_nxt;
			rw_r <= rw_nxt;
			cnt_r <= cnt_nxt;
			adr_r <= adr_nxt;
			sh_r <= sh_nxt;
			out_r <= out_nxt;
			sdo_r <= sdo_nxt;
			oe_n_r <= oe_n_nxt;
			pf_r <= pf_nxt;
			cl_r <= cl_nxt;
			bus_r <= bus_nxt;
		end
	end

	assign bus = bus_r;
	assign sdo = sdo_r;
	assign sdo_oe_n = oe_n_r;
endmodule

// ===== core/rms_top.sv
// rms_top: operating mode sequencer, status and interrupt logic.
// assumes a host on the serial port and event pulses from the modem.
//
// Summary of operation
// - shutdown pin high resets registers to defaults and silences serial port.
// - falling shutdown pin starts the power-on reset delay.
// - after reset, soft reset or shutdown, idle ready with crystal.
// - mode value zero gives standby, registers kept and accessible.
// - wake-timer bit selects sleep with low-power regulator and timer.
// - battery detect bit enables detector in sensor mode.
// - crystal-on bit gives ready mode, oscillator kept running.
// - synthesizer-on bit gives tune, crystal forced on.
// - receive-on bit moves any idle mode into receive.
// - regulators, crystal wait, synth, calibrate, settle, front, modem.
// - calibration skipped when its enable is zero; enable resets one.
// - low-power regulator alone only in standby and sleep.
// - receive reached about 16.8 ms, 800 us or 200 us after start.
// - status register reports fifo, header, frequency and power state.
// - interrupt pin low while any enabled flag is set.
// - pin stays low until the flag's status register is read.
// - reading a status register clears its enabled flags.
// - disabled events set flags but never drive the pin.
// - enable registers gate flags; only power-on enabled after reset.
// - 16-bit serial frames: write bit, 7-bit address, 8 data bits.
`timescale 1ns/10ps
module rms_top #(
	parameter int P_POR_CYC  = rms_pkg::POR_CYC,
	parameter int P_XTAL_CYC = rms_pkg::XTAL_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        shutdown_pin,
	input  wire logic        spi_sclk,
	input  wire logic        spi_sdi,
	input  wire logic        spi_sel_n,
	input  wire logic [15:0] evt,
	input  wire logic [4:0]  dstat_in,
	output logic             spi_sdo,
	output logic             spi_sdo_oe_n,
	output logic             irq_out_n,
	output logic             xosc_bufovr,
	output rms_pkg::rms_pwr_t pwr
);
	import rms_pkg::*;

	rms_bus_t   bus;
	rms_state_t st_r, st_nxt;
	logic       xok_r, xok_nxt;
	logic       pend_r, pend_nxt;
	logic [7:0] mode_r, mode_nxt;
	logic [7:0] seqc_r, seqc_nxt;
	logic [7:0] xosc_r, xosc_nxt;
	logic [15:0] ien_r, ien_nxt;
	logic [15:0] ist_r, ist_nxt;
	logic [15:0] ev_all;
	logic       irq_n_r, irq_n_nxt;
	rms_pwr_t   pwr_r, pwr_nxt;
	logic       por_ev;
	logic       rdy_ev;
	logic       swres;
	logic       t_start;
	logic [TW-1:0] t_load;
	logic       t_done;
	logic [7:0] rdata;
	logic [1:0] cps;
	logic       rxon, xton, pllon;
	logic       in_rx_path;

	assign rxon = mode_r[MB_RXON];
	assign xton = mode_r[MB_XTON];
	assign pllon = mode_r[MB_PLLON];
	assign in_rx_path = (st_r == ST_SYN) || (st_r == ST_CAL) ||
		(st_r == ST_SET) || (st_r == ST_RXFE) || (st_r == ST_RX);

	// serial port is gated off in shutdown
	rms_spi u_spi (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.en       (st_r != ST_SHDN),
		.sclk     (spi_sclk),
		.sdi      (spi_sdi),
		.sel_n    (spi_sel_n),
		.rdata    (rdata),
		.bus      (bus),
		.sdo      (spi_sdo),
		.sdo_oe_n (spi_sdo_oe_n)
	);

	// one timer serves every wait of the sequence
	rms_tmr #(
		.W (TW)
	) u_tmr (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.start   (t_start),
		.load    (t_load),
		.done    (t_done)
	);

	// sequencer next state
	always_comb begin
		st_nxt = st_r;
		xok_nxt = xok_r;
		t_start = 1'b0;
		t_load = '0;
		por_ev = 1'b0;
		rdy_ev = 1'b0;
		case (st_r)
			ST_SHDN: begin
				if (!shutdown_pin) begin
					st_nxt = ST_POR;
					t_start = 1'b1;
					t_load = TW'(P_POR_CYC);
				end
			end
			ST_POR: begin
				if (t_done) begin
					st_nxt = ST_IDLE;
					por_ev = 1'b1;
				end
			end
			ST_IDLE: begin
				if ((rxon || xton || pllon) && !xok_r) begin
					st_nxt = ST_XTAL;
					t_start = 1'b1;
					t_load = TW'(P_XTAL_CYC);
				end else if (rxon) begin
					st_nxt = ST_SYN;
				end
				if (!(rxon || xton || pllon)) begin
					xok_nxt = 1'b0;
				end
			end
			ST_XTAL: begin
				if (t_done) begin
					xok_nxt = 1'b1;
					rdy_ev = 1'b1;
					st_nxt = rxon ? ST_SYN : ST_IDLE;
				end
			end
			ST_SYN: begin
				t_start = 1'b1;
				if (seqc_r[SB_CAL]) begin
					st_nxt = ST_CAL;
					t_load = TW'(CAL_CYC);
				end else begin
					st_nxt = ST_SET;
					t_load = TW'(SETTLE_CYC);
				end
			end
			ST_CAL: begin
				if (t_done) begin
					st_nxt = ST_SET;
					t_start = 1'b1;
					t_load = TW'(SETTLE_CYC);
				end
			end
			ST_SET: begin
				if (t_done) begin
					st_nxt = ST_RXFE;
				end
			end
			ST_RXFE: begin
				st_nxt = ST_RX;
			end
			ST_RX: begin
				st_nxt = ST_RX;
			end
			default: begin
				st_nxt = ST_SHDN;
			end
		endcase
		if (in_rx_path && !rxon) begin
			st_nxt = ST_IDLE;
		end
		if (swres) begin
			st_nxt = ST_POR;
			xok_nxt = 1'b0;
			t_start = 1'b1;
			t_load = TW'(P_POR_CYC);
		end
		if (shutdown_pin) begin
			st_nxt = ST_SHDN;
			xok_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= ST_SHDN;
			xok_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			xok_r <= xok_nxt;
		end
	end

	// internal events join the external ones; reserved bits stay zero
	assign ev_all = {evt[15:10], rdy_ev, por_ev, evt[7:0] & IST1_USED};

	// register file next values
	always_comb begin
		mode_nxt = mode_r;
		seqc_nxt = seqc_r;
		xosc_nxt = xosc_r;
		ien_nxt = ien_r;
		ist_nxt = ist_r;
		pend_nxt = pend_r;
		swres = 1'b0;
		if (bus.rd && bus.addr == ADR_IST1) begin
			ist_nxt[7:0] = ist_r[7:0] & ~ien_r[7:0];
		end
		if (bus.rd && bus.addr == ADR_IST2) begin
			ist_nxt[15:8] = ist_r[15:8] & ~ien_r[15:8];
			pend_nxt = 1'b0;
		end
		ist_nxt = ist_nxt | ev_all;
		if (bus.wr) begin
			case (bus.addr)
				ADR_IEN1: ien_nxt[7:0] = bus.wdata & IST1_USED;
				ADR_IEN2: ien_nxt[15:8] = bus.wdata;
				ADR_MODE: begin
					if (bus.wdata[MB_SWRES]) begin
						swres = 1'b1;
					end else begin
						mode_nxt = bus.wdata;
					end
				end
				ADR_SEQC: seqc_nxt = {7'h00, bus.wdata[SB_CAL]};
				ADR_XOSC: xosc_nxt = {6'h00, bus.wdata[XB_BUFOVR], 1'b0};
				default: mode_nxt = mode_r;
			endcase
		end
		if (st_r == ST_SHDN || st_r == ST_POR || swres) begin
			mode_nxt = MODE_RST;
			seqc_nxt = SEQC_RST;
			xosc_nxt = XOSC_RST;
			ien_nxt = {IEN2_RST, IEN1_RST};
			ist_nxt = ev_all;
			pend_nxt = 1'b1;
		end
		if (st_r == ST_SHDN) begin
			ist_nxt = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= MODE_RST;
			seqc_r <= SEQC_RST;
			xosc_r <= XOSC_RST;
			ien_r <= {IEN2_RST, IEN1_RST};
			ist_r <= 16'h0000;
			pend_r <= 1'b1;
		end else begin
			mode_r <= mode_nxt;
			seqc_r <= seqc_nxt;
			xosc_r <= xosc_nxt;
			ien_r <= ien_nxt;
			ist_r <= ist_nxt;
			pend_r <= pend_nxt;
		end
	end

	// power state code for the status register
	always_comb begin
		cps = CPS_IDLE;
		if (st_r == ST_RX) begin
			cps = CPS_RX;
		end else if (pwr_r.synth) begin
			cps = CPS_TUNE;
		end
	end

	// read data mux; unmapped addresses read as zero
	always_comb begin
		case (bus.addr)
			ADR_STAT: rdata = {dstat_in, 1'b0, cps};
			ADR_IST1: rdata = ist_r[7:0];
			ADR_IST2: rdata = ist_r[15:8];
			ADR_IEN1: rdata = ien_r[7:0];
			ADR_IEN2: rdata = ien_r[15:8];
			ADR_MODE: rdata = mode_r;
			ADR_SEQC: rdata = seqc_r;
			ADR_XOSC: rdata = xosc_r;
			default:  rdata = 8'h00;
		endcase
	end

	// block enables; main regulator stays on until status 2 is read,
	// since low-power idle without that read would draw extra current
	always_comb begin
		pwr_nxt = '0;
		pwr_nxt.lp_reg = (st_r != ST_SHDN);
		pwr_nxt.main_reg = pwr_nxt.lp_reg && !((st_r == ST_IDLE) &&
			!(rxon || xton || pllon || mode_r[MB_LBD]) && !pend_r);
		pwr_nxt.xtal = (st_r == ST_XTAL) || in_rx_path ||
			((st_r == ST_IDLE) && (xton || pllon));
		pwr_nxt.synth = in_rx_path || ((st_r == ST_IDLE) && pllon && xok_r);
		pwr_nxt.rx_fe = (st_r == ST_RXFE) || (st_r == ST_RX);
		pwr_nxt.modem_rx = (st_r == ST_RX);
		pwr_nxt.wut = pwr_nxt.lp_reg && mode_r[MB_WT];
		pwr_nxt.lbd = pwr_nxt.lp_reg && mode_r[MB_LBD];
		irq_n_nxt = ~|(ist_r & ien_r) || (st_r == ST_SHDN);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwr_r <= '0;
			irq_n_r <= 1'b1;
		end else begin
			pwr_r <= pwr_nxt;
			irq_n_r <= irq_n_nxt;
		end
	end

	assign pwr = pwr_r;
	assign irq_out_n = irq_n_r;
	assign xosc_bufovr = xosc_r[XB_BUFOVR];

	property p_shdn;
		@(posedge ref_clk) disable iff (!arst_n)
		shutdown_pin |=> (st_r == ST_SHDN) ##1 !pwr.lp_reg;
	endproperty
	a_shdn: assert property (p_shdn)
		else $error("shutdown pin did not stop the block");

	property p_por;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_r == ST_SHDN && !shutdown_pin) |=> (st_r == ST_POR);
	endproperty
	a_por: assert property (p_por)
		else $error("no reset sequence after shutdown release");

	property p_ready;
		@(posedge ref_clk) disable iff (!arst_n)
		($past(st_r) == ST_POR && st_r == ST_IDLE) |->
			(mode_r == MODE_RST) && ien_r == {IEN2_RST, IEN1_RST};
	endproperty
	a_ready: assert property (p_ready)
		else $error("reset did not land in ready defaults");

	property p_irq;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_r != ST_SHDN && (ist_r & ien_r) != 16'h0000) |=> !irq_out_n;
	endproperty
	a_irq: assert property (p_irq)
		else $error("enabled flag did not pull interrupt low");

	property p_mask;
		@(posedge ref_clk) disable iff (!arst_n)
		((ist_r & ien_r) == 16'h0000) |=> irq_out_n;
	endproperty
	a_mask: assert property (p_mask)
		else $error("interrupt low with no enabled flag");

	property p_rdclr;
		@(posedge ref_clk) disable iff (!arst_n)
		(bus.rd && bus.addr == ADR_IST1 && ev_all[7:0] == 8'h00 &&
			st_r != ST_SHDN && st_r != ST_POR)
			|=> (ist_r[7:0] & ien_r[7:0]) == 8'h00;
	endproperty
	a_rdclr: assert property (p_rdclr)
		else $error("status read left an enabled flag set");

	property p_skip;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_r == ST_SYN && !seqc_r[SB_CAL] && rxon && !shutdown_pin &&
			!swres) |=> (st_r == ST_SET);
	endproperty
	a_skip: assert property (p_skip)
		else $error("calibration not skipped");

	property p_order;
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(st_r == ST_RX) |-> $past(st_r) == ST_RXFE;
	endproperty
	a_order: assert property (p_order)
		else $error("receive entered out of order");

	property p_main;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_r == ST_RX) |=> pwr.main_reg && pwr.xtal;
	endproperty
	a_main: assert property (p_main)
		else $error("main regulator off in receive");

	property p_exit;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_r == ST_RX && !rxon && !shutdown_pin && !swres)
			|=> (st_r == ST_IDLE);
	endproperty
	a_exit: assert property (p_exit)
		else $error("receive not left after receive-on cleared");
endmodule

// ===== bench/rms_host.sv
// rms_host: host controller model on the serial register port.
// assumes ref_clk is shared with the device; the bench calls xfer.
`timescale 1ns/10ps
module rms_host (
	input  wire logic ref_clk,
	input  wire logic spi_sdo,
	input  wire logic spi_sdo_oe_n,
	output logic      spi_sclk,
	output logic      spi_sdi,
	output logic      spi_sel_n
);
	logic sdo_w;

	// data out has a pull-up, so a released line reads high
	assign sdo_w = spi_sdo_oe_n ? 1'b1 : spi_sdo;

	// pins idle deselected with the clock low
	initial begin
		spi_sclk  = 1'b0;
		spi_sdi   = 1'b0;
		spi_sel_n = 1'b1;
	end

	// sixteen bit frame
	// write flag, 7-bit address, 8 data bits, msb first
	task automatic xfer(input logic wr, input logic [6:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic [15:0] f;
		f = {wr, a, d};
		q = 8'h00;
		@(negedge ref_clk);
		spi_sel_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_sclk = 1'b0;
			spi_sdi  = f[i];
			// 4 cycles per phase, one more than the port needs
			repeat (4) @(negedge ref_clk);
			if (i < 8)
				q[i] = sdo_w;
			spi_sclk = 1'b1;
			repeat (4) @(negedge ref_clk);
		end
		spi_sclk = 1'b0;
		repeat (4) @(negedge ref_clk);
		spi_sel_n = 1'b1;
		spi_sdi   = ~spi_sdi; // released: never leave a stale bit
		repeat (2) @(negedge ref_clk);
	endtask
endmodule

// ===== bench/rms_top_bench.sv
// rms_top_bench: register level checks of the mode sequencer.
// assumes short power-on and crystal counts set by parameter.
`timescale 1ns/10ps
module rms_top_bench;
	import rms_pkg::*;
	localparam int POR  = 50;
	localparam int XT   = 20;
	localparam int WAKE = POR + XT + 30;
	localparam int FST  = CAL_CYC + SETTLE_CYC;
	localparam logic [7:0] MD [4] = '{8'h00, 8'h40, 8'h60, 8'h01};
	localparam logic [7:0] EX [4] = '{8'h80, 8'h82, 8'h43, 8'h60};
	localparam logic [7:0] MK [4] = '{8'hff, 8'hff, 8'h7f, 8'h7f};

	logic        ref_clk;
	logic        arst_n;
	logic        shutdown_pin;
	logic [15:0] evt;
	logic [4:0]  dstat_in;
	logic        spi_sclk;
	logic        spi_sdi;
	logic        spi_sel_n;
	logic        spi_sdo;
	logic        spi_sdo_oe_n;
	logic        irq_out_n;
	logic        xosc_bufovr;
	rms_pwr_t    pwr;
	int          failures;
	int          cmp_count;
	int          cycles;
	logic [7:0]  q_ist;

	rms_top #(
		.P_POR_CYC  (POR),
		.P_XTAL_CYC (XT)
	) u_dut (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.shutdown_pin (shutdown_pin),
		.spi_sclk     (spi_sclk),
		.spi_sdi      (spi_sdi),
		.spi_sel_n    (spi_sel_n),
		.evt          (evt),
		.dstat_in     (dstat_in),
		.spi_sdo      (spi_sdo),
		.spi_sdo_oe_n (spi_sdo_oe_n),
		.irq_out_n    (irq_out_n),
		.xosc_bufovr  (xosc_bufovr),
		.pwr          (pwr)
	);

	rms_host u_host (
		.ref_clk      (ref_clk),
		.spi_sdo      (spi_sdo),
		.spi_sdo_oe_n (spi_sdo_oe_n),
		.spi_sclk     (spi_sclk),
		.spi_sdi      (spi_sdi),
		.spi_sel_n    (spi_sel_n)
	);

	// 20 MHz reference clock
	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;

	// hang guard, well above the roughly 12000 cycles of the run
	initial cycles = 0;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		u_host.xfer(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		u_host.xfer(1'b0, a, 8'h00, r);
		chk(r, e);
	endtask

	// one-cycle event pulse, then time for the registered pin
	task automatic pulse(input logic [15:0] e);
		evt = e;
		@(negedge ref_clk);
		evt = 16'h0000;
		repeat (3) @(negedge ref_clk);
	endtask

	// wait for the modem, watching that enables come up in order
	task automatic to_rx(input int lo, input int hi);
		int   n;
		logic ok;
		n  = 0;
		ok = 1'b1;
		while (pwr.modem_rx !== 1'b1 && n < 9000) begin
			if ((pwr.rx_fe && !pwr.synth) || (pwr.synth && !pwr.xtal)
				|| (pwr.xtal && !pwr.main_reg))
				ok = 1'b0;
			@(negedge ref_clk);
			n++;
		end
		chk({7'h00, ok && n >= lo && n <= hi}, 8'h01);
		chk(pwr & 8'h7c, 8'h7c);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// main sequence; inputs change on the falling edge only
	initial begin
		failures     = 0;
		cmp_count    = 0;
		arst_n       = 1'b0;
		shutdown_pin = 1'b1;
		evt          = 16'h0000;
		dstat_in     = 5'h00;
		repeat (6) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk(pwr, 8'h00);
		rd(ADR_IEN2, 8'hff);
		shutdown_pin = 1'b0;
		repeat (WAKE) @(negedge ref_clk);
		chk(pwr & 8'h60, 8'h60);
		chk({7'h00, irq_out_n}, 8'h00);
		rd(ADR_IEN1, IEN1_RST);
		rd(ADR_IEN2, IEN2_RST);
		rd(ADR_SEQC, 8'h01);
		u_host.xfer(1'b0, ADR_IST2, 8'h00, q_ist);
		chk(q_ist & 8'h01, 8'h01);
		chk({7'h00, irq_out_n}, 8'h01);
		rd(ADR_IST2, q_ist & 8'hfe);
		// status is read only; unmapped places read zero
		dstat_in = 5'h15;
		rd(ADR_STAT, 8'ha8);
		wr(ADR_STAT, 8'hff);
		rd(ADR_STAT, 8'ha8);
		rd(7'h10, 8'h00);
		// one enabled and one masked event together
		wr(ADR_IEN1, 8'h80);
		pulse(16'h0090);
		chk({7'h00, irq_out_n}, 8'h00);
		rd(ADR_IST1, 8'h90);
		chk({7'h00, irq_out_n}, 8'h01);
		rd(ADR_IST1, 8'h10);
		pulse(16'h0010);
		chk({7'h00, irq_out_n}, 8'h01);
		// standby keeps registers writable
		wr(ADR_MODE, 8'h00);
		wr(ADR_IEN1, 8'h08);
		rd(ADR_IEN1, 8'h08);
		// standby, sleep, sensor and ready enables
		for (int i = 0; i < 4; i++) begin
			wr(ADR_MODE, MD[i]);
			repeat (4) @(negedge ref_clk);
			chk(pwr & MK[i], EX[i]);
		end
		// tune from standby turns the crystal on by itself
		wr(ADR_MODE, 8'h00);
		wr(ADR_MODE, 8'h02);
		repeat (XT + 10) @(negedge ref_clk);
		chk(pwr & 8'h7f, 8'h70);
		rd(ADR_STAT, 8'haa);
		// fast path from ready, then back to the selected idle
		wr(ADR_MODE, 8'h01);
		wr(ADR_MODE, 8'h05);
		to_rx(FST - 20, FST + 20);
		rd(ADR_STAT, 8'ha9);
		wr(ADR_MODE, 8'h01);
		repeat (4) @(negedge ref_clk);
		chk(pwr & 8'h7f, 8'h60);
		// full sequence from standby with calibration skipped
		wr(ADR_SEQC, 8'h00);
		wr(ADR_MODE, 8'h00);
		wr(ADR_MODE, 8'h04);
		to_rx(XT + SETTLE_CYC - 20, XT + SETTLE_CYC + 30);
		wr(ADR_MODE, 8'h00);
		repeat (4) @(negedge ref_clk);
		chk(pwr, 8'h80);
		// host sets then clears the buffer override
		wr(ADR_XOSC, 8'h02);
		chk({7'h00, xosc_bufovr}, 8'h01);
		wr(ADR_XOSC, 8'h00);
		chk({7'h00, xosc_bufovr}, 8'h00);
		// soft reset restores defaults and ready mode
		wr(ADR_IEN2, 8'hff);
		wr(ADR_MODE, 8'h80);
		repeat (WAKE) @(negedge ref_clk);
		rd(ADR_IEN2, IEN2_RST);
		rd(ADR_MODE, MODE_RST);
		chk(pwr & 8'h60, 8'h60);
		// shutdown in mid-run loses the written enables
		wr(ADR_IEN1, 8'hff);
		shutdown_pin = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk(pwr, 8'h00);
		chk({7'h00, irq_out_n}, 8'h01);
		shutdown_pin = 1'b0;
		repeat (WAKE) @(negedge ref_clk);
		chk({7'h00, irq_out_n}, 8'h00);
		rd(ADR_IEN1, IEN1_RST);
		// reading status 1 alone must leave status 2 pending
		rd(ADR_IST1, 8'h00);
		chk({7'h00, irq_out_n}, 8'h00);
		rd(ADR_IST2, 8'h03);
		chk({7'h00, irq_out_n}, 8'h01);
		give_verdict();
	end
endmodule
